// ---- hw/ipmr_readback.sv ----
// APB readback bank for product description and video rate packets.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "ipmr_cfg.svh"

module ipmr_readback
  import ipmr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        prod_load,
  input  wire logic [127:0] prod_text,
  input  wire logic [7:0]  prod_class,
  input  wire logic        rate_load,
  input  wire logic [7:0]  rate_version,
  input  wire logic [31:0] rate_value,
  input  wire logic        repeat_field_flag,
  input  wire logic [6:0]  new_data_flags
);

  // ***************************************************************
  // Captured packet contents
  // ***************************************************************

  logic [`IPMR_PROD_BYTES*8-1:0] prod_q;
  logic [`IPMR_RATE_BYTES*8-1:0] rate_q;
  logic [`IPMR_RATE_BYTES*8-1:0] rate_din;
  logic [`IPMR_FLAG_MSB:0]       flags_r;
  logic [7:0]                    sts_byte;

  // Only the repeat bit of the status byte carries information.
  always_comb begin
    sts_byte                   = `IPMR_RST_BYTE;
    sts_byte[`IPMR_REPEAT_BIT] = repeat_field_flag;
  end

  // The rate packet is stored as version, four rate bytes, status byte.
  assign rate_din = {sts_byte, rate_value, rate_version};

  // Only the receiver strobes load these; APB has no path into them.
  ipmr_capture #(
    .NB      (`IPMR_PROD_BYTES)
  ) u_prod (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (prod_load),
    .din     ({prod_class, prod_text}),
    .q       (prod_q)
  );

  ipmr_capture #(
    .NB      (`IPMR_RATE_BYTES)
  ) u_rate (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (rate_load),
    .din     (rate_din),
    .q       (rate_q)
  );

  // New-data flags come from receiver logic on this clock, so one register
  // is enough; it keeps the read path short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= '0;
    end else begin
      flags_r <= new_data_flags;
    end
  end

  // ***************************************************************
  // APB decode
  // ***************************************************************

  ipmr_apb_state_type apb_state_r;
  logic [7:0]         idx;
  logic               setup;
  logic               in_range;
  logic               wr_take;
  logic               rd_hit;
  logic [31:0]        rd_nxt;

  assign idx      = paddr[9:2];
  assign in_range = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign setup    = psel && !penable && (apb_state_r == IPMR_IDLE);
  assign wr_take  = psel && penable && pwrite && pready;

  // The slave answers in the first access cycle: pready rises at the setup
  // edge, together with the read data, and stands for exactly one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state_r <= IPMR_IDLE;
    end else begin
      case (apb_state_r)
        IPMR_IDLE: begin
          if (setup) begin
            apb_state_r <= IPMR_ACCESS;
          end
        end
        IPMR_ACCESS: begin
          apb_state_r <= IPMR_IDLE;
        end
        default: begin
          apb_state_r <= IPMR_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // Interrupt status and mask
  // ***************************************************************

  logic [`IPMR_INT_BITS-1:0] int_sts_r;
  logic [`IPMR_INT_BITS-1:0] int_mask_r;
  logic [`IPMR_INT_BITS-1:0] int_set;
  logic [`IPMR_INT_BITS-1:0] int_clr;
  logic                      wr_sts;
  logic                      wr_mask;

  assign int_set[`IPMR_INT_PROD] = prod_load;
  assign int_set[`IPMR_INT_RATE] = rate_load;
  assign wr_sts  = wr_take && in_range && (idx == `IPMR_IDX_INT_STS) && pstrb[0];
  assign wr_mask = wr_take && in_range && (idx == `IPMR_IDX_INT_MASK) && pstrb[0];
  assign int_clr = wr_sts ? pwdata[`IPMR_INT_BITS-1:0] : '0;

  // Sticky capture events; a new capture in the clearing cycle survives
  // because set is ORed in after the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_sts_r <= `IPMR_RST_INT;
    end else begin
      int_sts_r <= (int_sts_r & ~int_clr) | int_set;
    end
  end

  // Mask register: a one lets the matching status bit reach irq.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_r <= `IPMR_RST_INT;
    end else if (wr_mask) begin
      int_mask_r <= pwdata[`IPMR_INT_BITS-1:0];
    end
  end

  // Registered level output; it trails the status by one cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_sts_r & int_mask_r);
    end
  end

  // ***************************************************************
  // Read multiplexer
  // ***************************************************************

  // Text characters are 7-bit codes; bit 7 always reads zero.
  function automatic logic [31:0] chr(input int k);
    chr = {25'h0, prod_q[k*8 +: (`IPMR_CHAR_MSB + 1)]};
  endfunction : chr

  // Byte-wide registers sit in the low lanes and the rest reads zero.
  always_comb begin
    rd_nxt = `IPMR_RST_WORD;
    rd_hit = in_range;
    case (idx)
      `IPMR_IDX_TXT01:    rd_nxt = chr(0);
      `IPMR_IDX_TXT02:    rd_nxt = chr(1);
      `IPMR_IDX_TXT03:    rd_nxt = chr(2);
      `IPMR_IDX_TXT04:    rd_nxt = chr(3);
      `IPMR_IDX_TXT05:    rd_nxt = chr(4);
      `IPMR_IDX_TXT06:    rd_nxt = chr(5);
      `IPMR_IDX_TXT07:    rd_nxt = chr(6);
      `IPMR_IDX_TXT08:    rd_nxt = chr(7);
      `IPMR_IDX_TXT09:    rd_nxt = chr(8);
      `IPMR_IDX_TXT10:    rd_nxt = chr(9);
      `IPMR_IDX_TXT11:    rd_nxt = chr(10);
      `IPMR_IDX_TXT12:    rd_nxt = chr(11);
      `IPMR_IDX_TXT13:    rd_nxt = chr(12);
      `IPMR_IDX_TXT14:    rd_nxt = chr(13);
      `IPMR_IDX_TXT15:    rd_nxt = chr(14);
      `IPMR_IDX_TXT16:    rd_nxt = chr(15);
      `IPMR_IDX_FLAGS_A,
      `IPMR_IDX_FLAGS_B,
      `IPMR_IDX_FLAGS_C:  rd_nxt = {25'h0, flags_r};
      `IPMR_IDX_CLASS:    rd_nxt = {24'h0, prod_q[128 +: 8]};
      `IPMR_IDX_RATE_VER: rd_nxt = {24'h0, rate_q[0 +: 8]};
      `IPMR_IDX_RATE_B0:  rd_nxt = {24'h0, rate_q[8 +: 8]};
      `IPMR_IDX_RATE_B1:  rd_nxt = {24'h0, rate_q[16 +: 8]};
      `IPMR_IDX_RATE_B2:  rd_nxt = {24'h0, rate_q[24 +: 8]};
      `IPMR_IDX_RATE_B3:  rd_nxt = {24'h0, rate_q[32 +: 8]};
      `IPMR_IDX_RATE_STS: rd_nxt = {24'h0, rate_q[40 +: 8]};
      `IPMR_IDX_INT_STS:  rd_nxt = {30'h0, int_sts_r};
      `IPMR_IDX_INT_MASK: rd_nxt = {30'h0, int_mask_r};
      default:            rd_hit = 1'b0;
    endcase
    if (!rd_hit) begin
      rd_nxt = `IPMR_RST_WORD;
    end
  end

  // ***************************************************************
  // APB answer registers
  // ***************************************************************

  // pready pulses for one cycle after each setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  // Read data is sampled at the setup edge; writes return zero data.
  // Writes to packet registers are accepted without error but dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `IPMR_RST_WORD;
    end else if (setup) begin
      prdata <= pwrite ? `IPMR_RST_WORD : rd_nxt;
    end else if (pready) begin
      prdata <= `IPMR_RST_WORD;
    end
  end

  // Unmapped or misaligned addresses answer with an error, so software
  // finds a bad pointer instead of reading silent zeros.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup && !rd_hit;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************

  rd_char_one_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_TXT01, 2'b00})
    |=> pready && prdata == {25'h0, $past(prod_q[6:0])})
    else $error("First product character read back wrong.");

  rd_char_last_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_TXT16, 2'b00})
    |=> pready && prdata == {25'h0, $past(prod_q[120 +: 7])})
    else $error("Last product character read back wrong.");

  rd_char_six_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_TXT06, 2'b00})
    |=> prdata == {25'h0, $past(prod_q[40 +: 7])})
    else $error("Sixth product character read back wrong.");

  rd_flag_byte_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && (paddr == {2'b00, `IPMR_IDX_FLAGS_B, 2'b00}))
    |=> !pslverr && prdata == {25'h0, $past(new_data_flags, 2)})
    else $error("New-data flag byte read back wrong.");

  rd_class_code_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_CLASS, 2'b00})
    |=> prdata == {24'h0, $past(prod_q[128 +: 8])})
    else $error("Source class code read back wrong.");

  // Shadow of the last rate packet, built from the inputs alone, so the
  // rate checks hold at any distance between capture and read.
  logic [31:0] chk_rate_r;
  logic        chk_repeat_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_rate_r   <= `IPMR_RST_WORD;
      chk_repeat_r <= 1'b0;
    end else if (rate_load) begin
      chk_rate_r   <= rate_value;
      chk_repeat_r <= repeat_field_flag;
    end
  end

  rd_rate_high_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_RATE_B3, 2'b00})
    |=> prdata == {24'h0, $past(chk_rate_r[31:24])})
    else $error("Rate high byte does not match captured value.");

  rd_rate_low_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_RATE_B0, 2'b00})
    |=> prdata == {24'h0, $past(chk_rate_r[7:0])})
    else $error("Rate low byte does not match captured value.");

  rd_repeat_bit_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == {2'b00, `IPMR_IDX_RATE_STS, 2'b00})
    |=> prdata == {27'h0, $past(chk_repeat_r), 4'h0})
    else $error("Repeat field bit does not match captured value.");

  bad_addr_err_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && (paddr[1:0] != 2'b00 || paddr[11:10] != 2'b00)) |=> pready && pslverr)
    else $error("Misaligned or out-of-range address answered without error.");

  err_zero_data_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready && prdata == `IPMR_RST_WORD)
    else $error("Error answer came without ready or with data.");

  ro_hold_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    (!prod_load && !rate_load) |=> $stable(prod_q) && $stable(rate_q))
    else $error("Packet contents changed without a capture.");

  apb_ready_once_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("pready did not pulse for exactly one cycle.");

  irq_follow_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(int_sts_r) & $past(int_mask_r)))
    else $error("irq does not follow masked status.");

  int_set_win_a : assert property (
    @(posedge pclk) disable iff (!presetn)
    prod_load |=> int_sts_r[`IPMR_INT_PROD])
    else $error("Capture event lost against a clear.");

endmodule : ipmr_readback

// ---- hw/ipmr_cfg.svh ----
// Register indices, field positions and reset values of the packet readback bank.
`ifndef IPMR_CFG_SVH
`define IPMR_CFG_SVH

// Register indices; the APB byte address is four times the index.
`define IPMR_IDX_TXT01    8'ha2
`define IPMR_IDX_TXT02    8'ha3
`define IPMR_IDX_TXT03    8'ha4
`define IPMR_IDX_TXT04    8'ha5
`define IPMR_IDX_TXT05    8'ha6
`define IPMR_IDX_FLAGS_A  8'ha7
`define IPMR_IDX_TXT06    8'ha8
`define IPMR_IDX_TXT07    8'ha9
`define IPMR_IDX_TXT08    8'haa
`define IPMR_IDX_TXT09    8'hab
`define IPMR_IDX_TXT10    8'hac
`define IPMR_IDX_TXT11    8'had
`define IPMR_IDX_TXT12    8'hae
`define IPMR_IDX_FLAGS_B  8'haf
`define IPMR_IDX_TXT13    8'hb0
`define IPMR_IDX_TXT14    8'hb1
`define IPMR_IDX_TXT15    8'hb2
`define IPMR_IDX_TXT16    8'hb3
`define IPMR_IDX_CLASS    8'hb4
`define IPMR_IDX_FLAGS_C  8'hb7
`define IPMR_IDX_RATE_VER 8'hb8
`define IPMR_IDX_RATE_B0  8'hb9
`define IPMR_IDX_RATE_B1  8'hba
`define IPMR_IDX_RATE_B2  8'hbb
`define IPMR_IDX_RATE_B3  8'hbc
`define IPMR_IDX_RATE_STS 8'hbd
`define IPMR_IDX_INT_STS  8'he0
`define IPMR_IDX_INT_MASK 8'he1

// Packet byte counts and field positions.
`define IPMR_PROD_BYTES   17
`define IPMR_RATE_BYTES   6
`define IPMR_CHAR_MSB     6
`define IPMR_FLAG_MSB     6
`define IPMR_REPEAT_BIT   4
`define IPMR_INT_BITS     2
`define IPMR_INT_PROD     0
`define IPMR_INT_RATE     1

// Reset values.
`define IPMR_RST_BYTE     8'h00
`define IPMR_RST_WORD     32'h0000_0000
`define IPMR_RST_INT      2'h0

`endif

// ---- hw/ipmr_pkg.sv ----
// Types shared by the packet readback bank.
package ipmr_pkg;

  // APB slave phase, one-hot.
  typedef enum logic [1:0] {
    IPMR_IDLE   = 2'b01,
    IPMR_ACCESS = 2'b10
  } ipmr_apb_state_type;

endpackage : ipmr_pkg

// ---- hw/ipmr_capture.sv ----
// Byte-wide packet holding registers loaded by a capture strobe.
`timescale 1ns/1ps
`include "ipmr_cfg.svh"

module ipmr_capture
  import ipmr_pkg::*;
#(
  parameter int NB = 1
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            load,
  input  wire logic [NB*8-1:0] din,
  output logic      [NB*8-1:0] q
);

  // ***************************************************************
  // Storage
  // ***************************************************************

  // Each byte only follows the receiver on a capture strobe, so a packet
  // is always seen whole and never half old, half new.
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_byte
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          q[gi*8 +: 8] <= `IPMR_RST_BYTE;
        end else if (load) begin
          q[gi*8 +: 8] <= din[gi*8 +: 8];
        end
      end
    end
  endgenerate

endmodule : ipmr_capture

// ---- dv/ipmr_source_model.sv ----
// Behavioural video source that hands captured packets to the readback bank.
`timescale 1ns/1ps

module ipmr_source_model (
  input  wire logic         pclk,
  output logic              prod_load,
  output logic      [127:0] prod_text,
  output logic      [7:0]   prod_class,
  output logic              rate_load,
  output logic      [7:0]   rate_version,
  output logic      [31:0]  rate_value,
  output logic              repeat_field_flag,
  output logic      [6:0]   new_data_flags
);
  // Strobes idle low; the field lines start at a junk pattern.
  initial begin
    prod_load = 1'b0;
    rate_load = 1'b0;
    prod_text = {4{32'hdead_beef}};
    prod_class = 8'ha5;
    rate_version = 8'h5a;
    rate_value = 32'hc3c3_c3c3;
    repeat_field_flag = 1'b1;
    new_data_flags = 7'h55;
  end

  // One product packet after gap idle cycles (gap of at least one).
  // Fields are inverted right after the load edge, so a late sample reads garbage.
  task automatic send_prod(input logic [127:0] text, input logic [7:0] cls, input int gap);
    repeat (gap) @(posedge pclk);
    prod_text <= text;
    prod_class <= cls;
    prod_load <= 1'b1;
    @(posedge pclk);
    prod_load <= 1'b0;
    prod_text <= ~text;
    prod_class <= ~cls;
  endtask : send_prod

  // One rate packet, same timing and the same hostile hold behaviour.
  task automatic send_rate(input logic [31:0] rate, input logic [7:0] ver, input logic rpt,
                           input int gap);
    repeat (gap) @(posedge pclk);
    rate_value <= rate;
    rate_version <= ver;
    repeat_field_flag <= rpt;
    rate_load <= 1'b1;
    @(posedge pclk);
    rate_load <= 1'b0;
    rate_value <= ~rate;
    rate_version <= ~ver;
    repeat_field_flag <= ~rpt;
  endtask : send_rate

  // Live flag levels change on an edge and then stay.
  task automatic set_flags(input logic [6:0] f);
    @(posedge pclk);
    new_data_flags <= f;
  endtask : set_flags
endmodule : ipmr_source_model

// ---- dv/test_infoframe_product_mpeg_readback.sv ----
// Self-checking bench for the packet readback bank.
`timescale 1ns/1ps
`include "ipmr_cfg.svh"

module test_infoframe_product_mpeg_readback;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, seed, rnd, rate, rate_value;
  logic [3:0]   pstrb, strb;
  logic         prod_load, rate_load, repeat_field_flag;
  logic [127:0] prod_text, text;
  logic [7:0]   prod_class, rate_version, idx;
  logic [6:0]   new_data_flags;
  logic [33:0]  exp_q[$];
  logic [33:0]  ent;
  int           fail_count, n_tests;

  ipmr_readback i_ipmr_readback (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .prod_load(prod_load),
    .prod_text(prod_text), .prod_class(prod_class), .rate_load(rate_load),
    .rate_version(rate_version), .rate_value(rate_value),
    .repeat_field_flag(repeat_field_flag), .new_data_flags(new_data_flags));

  ipmr_source_model i_ipmr_source_model (.pclk(pclk), .prod_load(prod_load),
    .prod_text(prod_text), .prod_class(prod_class), .rate_load(rate_load),
    .rate_version(rate_version), .rate_value(rate_value),
    .repeat_field_flag(repeat_field_flag), .new_data_flags(new_data_flags));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("Checks made: %0d, mismatches: %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // One APB transfer; the answer is noted first and judged by the monitor.
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e, input logic err);
    int n = 0;
    exp_q.push_back({!w, err, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : xfer

  task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic err);
    xfer({2'h0, i, 2'h0}, 1'b0, 32'h0, e, err);
  endtask : rd

  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    xfer({2'h0, i, 2'h0}, 1'b1, d, 32'h0, 1'b0);
  endtask : wr

  // The level output lags its cause by one edge, so two edges are let pass.
  task automatic irq_is(input logic e);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  // ****************************************
  // Clock, monitor and watchdog
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Every answer must match the oldest note; an unrequested answer is a fault.
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail_count++;
        $display("BAD t=%0t seen=%h exp=none", $time, prdata);
      end else begin
        ent = exp_q.pop_front();
        check({31'h0, pslverr}, {31'h0, ent[32]});
        if (ent[33]) check(prdata, ent[31:0]);
      end
    end
  end

  initial begin
    #5_000_000;
    fail_count++;
    results();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    strb = 4'hf;
    seed = 32'h0000_005e;
    fail_count = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IPMR_IDX_INT_STS, 32'h0, 1'b0);
    rd(`IPMR_IDX_INT_MASK, 32'h0, 1'b0);
    rd(`IPMR_IDX_TXT01, 32'h0, 1'b0);
    irq_is(1'b0);
    // Class codes 0 to 9, with fresh text and varied spacing each time.
    for (int c = 0; c < 10; c++) begin
      text = {xs(), xs(), xs(), xs()};
      i_ipmr_source_model.send_prod(text, c[7:0], 1 + c % 3);
      for (int i = 0; i < 16; i++) begin
        idx = 8'ha2 + i[7:0] + {7'h0, i >= 5} + {7'h0, i >= 12};
        rd(idx, {25'h0, text[i*8 +: 7]}, 1'b0);
      end
      rd(`IPMR_IDX_CLASS, {24'h0, c[7:0]}, 1'b0);
    end
    // Flag bytes show the live flags at all three places.
    for (int k = 0; k < 3; k++) begin
      rnd = xs();
      i_ipmr_source_model.set_flags(rnd[6:0]);
      rd(`IPMR_IDX_FLAGS_A, {25'h0, rnd[6:0]}, 1'b0);
      rd(`IPMR_IDX_FLAGS_B, {25'h0, rnd[6:0]}, 1'b0);
      rd(`IPMR_IDX_FLAGS_C, {25'h0, rnd[6:0]}, 1'b0);
    end
    // Rate packets with both field-repeat values.
    for (int k = 0; k < 2; k++) begin
      rate = xs();
      rnd = xs();
      i_ipmr_source_model.send_rate(rate, rnd[7:0], k[0], 3 - 2 * k);
      for (int j = 0; j < 4; j++) rd(8'hb9 + j[7:0], {24'h0, rate[j*8 +: 8]}, 1'b0);
      rd(`IPMR_IDX_RATE_VER, {24'h0, rnd[7:0]}, 1'b0);
      rd(`IPMR_IDX_RATE_STS, {27'h0, k[0], 4'h0}, 1'b0);
    end
    // Host writes to packet places are taken without error and change nothing.
    wr(`IPMR_IDX_TXT16, 32'hffff_ffff);
    wr(`IPMR_IDX_RATE_B3, 32'h0000_0000);
    wr(`IPMR_IDX_FLAGS_B, 32'hffff_ffff);
    rd(`IPMR_IDX_TXT16, {25'h0, text[126:120]}, 1'b0);
    rd(`IPMR_IDX_RATE_B3, {24'h0, rate[31:24]}, 1'b0);
    rd(`IPMR_IDX_FLAGS_B, {25'h0, new_data_flags}, 1'b0);
    // Unmapped and misaligned places answer with an error and zero data.
    rd(8'hb5, 32'h0, 1'b1);
    rd(8'hbe, 32'h0, 1'b1);
    xfer(12'h289, 1'b0, 32'h0, 32'h0, 1'b1);
    xfer(12'h688, 1'b1, 32'h1, 32'h0, 1'b1);
    // Interrupt: both events seen, masked, enabled, cleared, raised again.
    rd(`IPMR_IDX_INT_STS, 32'h3, 1'b0);
    irq_is(1'b0);
    wr(`IPMR_IDX_INT_MASK, 32'h1);
    irq_is(1'b1);
    wr(`IPMR_IDX_INT_STS, 32'h1);
    irq_is(1'b0);
    rd(`IPMR_IDX_INT_STS, 32'h2, 1'b0);
    wr(`IPMR_IDX_INT_MASK, 32'h2);
    rd(`IPMR_IDX_INT_MASK, 32'h2, 1'b0);
    irq_is(1'b1);
    wr(`IPMR_IDX_INT_STS, 32'h2);
    irq_is(1'b0);
    i_ipmr_source_model.send_rate(rate, 8'h01, 1'b0, 1);
    irq_is(1'b1);
    // A status write without the low byte strobe clears nothing.
    strb = 4'he;
    wr(`IPMR_IDX_INT_STS, 32'h3);
    strb = 4'hf;
    rd(`IPMR_IDX_INT_STS, 32'h2, 1'b0);
    irq_is(1'b1);
    repeat (3) @(posedge pclk);
    if (exp_q.size() != 0) fail_count++;
    results();
  end
endmodule : test_infoframe_product_mpeg_readback
